// File: dv/rcf_src_model.sv
// behavioural model of the on-chip reset sources that drive the flag register
`timescale 1ns/1ps
module rcf_src_model (
   input  wire logic        pclk,
   output rcf_pkg::rcf_src_t src
);
   import rcf_pkg::*;
   initial src = '0;
   // sources are levels held for a few cycles, like a real reset request
   task automatic fire(input int idx, input int cycles);
      src[idx] <= 1'b1;
      repeat (cycles) @(posedge pclk);
      src[idx] <= 1'b0;
      @(posedge pclk);
   endtask
endmodule

// File: dv/test_reset_cause_flags.sv
// self-checking bench for the reset-cause flag register
`timescale 1ns/1ps
module test_reset_cause_flags;
   import rcf_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   rcf_src_t    src;
   int          failures, check_count;
   localparam logic [11:0] A_CAUSE = {RCF_IDX_CAUSE, 2'b00};
   localparam logic [11:0] A_MASK  = {RCF_IDX_MASK, 2'b00};

   rcf_top rcf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src(src), .irq(irq));
   rcf_src_model rcf_src_model_i (.pclk(pclk), .src(src));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic conclude;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // entered just after a rising edge; pready and read data are taken at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
      chk({31'b0, e}, {31'b0, a != A_CAUSE && a != A_MASK});
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk({31'b0, e}, {31'b0, a != A_CAUSE && a != A_MASK});
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({31'b0, irq}, {31'b0, exp});
      @(posedge pclk);
   endtask

   task automatic t_por;
      rd(A_CAUSE, 32'h0000_0060);
      rd(A_CAUSE, 32'h0000_0060);
      rd(A_MASK, 32'h0000_0000);
      $display("test por done");
   endtask

   task automatic t_w1c;
      wr(A_CAUSE, 32'h0000_0094);
      rd(A_CAUSE, 32'h0000_0060);
      wr(12'h020, 32'h0000_00ff);
      rd(12'h020, 32'h0000_0000);
      wr(A_CAUSE, 32'h0000_0040);
      rd(A_CAUSE, 32'h0000_0020);
      pstrb <= 4'h0;
      wr(A_CAUSE, 32'h0000_0020);
      pstrb <= 4'h1;
      rd(A_CAUSE, 32'h0000_0020);
      wr(A_CAUSE, 32'h0000_0020);
      rd(A_CAUSE, 32'h0000_0000);
      $display("test w1c done");
   endtask

   task automatic t_events;
      int pos [6] = '{5, 5, 5, 3, 1, 0};
      for (int i = 0; i < 6; i++) begin
         rcf_src_model_i.fire(6 - i, 3);
         repeat (4) @(posedge pclk);
         rd(A_CAUSE, 32'h1 << pos[i]);
         wr(A_CAUSE, 32'h0000_00ff);
         rd(A_CAUSE, 32'h0000_0000);
      end
      $display("test events done");
   endtask

   task automatic t_sysrst_irq;
      rcf_src_model_i.fire(3, 3);
      repeat (4) @(posedge pclk);
      wr(A_MASK, 32'h0000_0002);
      irq_is(1'b0);
      wr(A_MASK, 32'h0000_0008);
      irq_is(1'b1);
      rcf_src_model_i.fire(0, 3);
      repeat (4) @(posedge pclk);
      rd(A_CAUSE, 32'h0000_0008);
      rd(A_MASK, 32'h0000_0000);
      irq_is(1'b0);
      wr(A_MASK, 32'h0000_0008);
      irq_is(1'b1);
      wr(A_CAUSE, 32'h0000_0008);
      irq_is(1'b0);
      $display("test system reset and interrupt done");
   endtask

   task automatic t_repor;
      rcf_src_model_i.fire(2, 3);
      repeat (4) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_CAUSE, 32'h0000_0060);
      $display("test second power-on done");
   endtask

   initial begin
      failures = 0;
      check_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_por();
      t_w1c();
      t_events();
      t_sysrst_irq();
      t_repor();
      conclude();
   end
endmodule

// File: src/rcf_pkg.sv
package rcf_pkg;

   localparam int unsigned RCF_ADDR_W   = 12;
   localparam int unsigned RCF_DATA_W   = 32;

   // register indices; byte address is four times the index
   localparam logic [9:0]  RCF_IDX_CAUSE = 10'h003;
   localparam logic [9:0]  RCF_IDX_MASK  = 10'h004;

   localparam int unsigned RCF_BIT_PLL  = 0;
   localparam int unsigned RCF_BIT_OSC  = 1;
   localparam int unsigned RCF_BIT_WDOG = 3;
   localparam int unsigned RCF_BIT_LV   = 5;
   localparam int unsigned RCF_BIT_POR  = 6;

   localparam logic [7:0]  RCF_IMPL_MASK = 8'h6b;
   localparam logic [7:0]  RCF_CAUSE_POR = 8'h60;
   localparam logic [7:0]  RCF_MASK_RST  = 8'h00;

   // on-chip reset sources, asynchronous to pclk
   typedef struct packed {
      logic lvr_core;
      logic lvr_nvm_supply;
      logic lvr_pad_supply;
      logic watchdog_timer;
      logic osc_monitor;
      logic pll_monitor;
      logic system_reset;
   } rcf_src_t;

   typedef struct packed {
      rcf_src_t   sync1;
      rcf_src_t   sync2;
      logic [7:0] cause;
      logic [7:0] mask;
      logic       pready;
      logic       pslverr;
      logic [7:0] prdata;
      logic       irq;
   } rcf_state_t;

   localparam rcf_state_t RCF_STATE_RST = '{
      sync1:   '0,
      sync2:   '0,
      cause:   RCF_CAUSE_POR,
      mask:    RCF_MASK_RST,
      pready:  1'b0,
      pslverr: 1'b0,
      prdata:  8'h00,
      irq:     1'b0
   };

endpackage

// File: src/rcf_top.sv
// reset-cause flag register with apb slave and masked interrupt
`timescale 1ns/1ps
module rcf_top #(
   parameter int unsigned ADDR_W = rcf_pkg::RCF_ADDR_W
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [ADDR_W-1:0]            paddr,
   input  wire logic [rcf_pkg::RCF_DATA_W-1:0] pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic      [rcf_pkg::RCF_DATA_W-1:0] prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire rcf_pkg::rcf_src_t            src,
   output logic                              irq
);
   import rcf_pkg::*;

   // every check below runs on pclk and is off while power-on reset is held
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   rcf_state_t q_reg;
   rcf_state_t q_next;

   logic       access;
   logic       done;
   logic       wr_done;
   logic       sys_rst;
   logic [7:0] set_bits;
   logic [7:0] cause_clr;
   logic [7:0] mask_wr;
   logic       hit_cause;
   logic       hit_mask;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
      logic [ADDR_W-1:0] full;
      full = ADDR_W'({idx, 2'b00});
      reg_hit = (a == full);
   endfunction

   // maps the synchronised sources, all but system reset, onto their flag positions
   function automatic logic [7:0] cause_bits(input rcf_src_t s);
      logic [7:0] b;
      b = 8'h00;
      b[RCF_BIT_LV]   = s.lvr_core | s.lvr_nvm_supply | s.lvr_pad_supply;
      b[RCF_BIT_WDOG] = s.watchdog_timer;
      b[RCF_BIT_OSC]  = s.osc_monitor;
      b[RCF_BIT_PLL]  = s.pll_monitor;
      cause_bits = b;
   endfunction

   assign access    = psel & penable;
   assign done      = access & q_reg.pready;
   assign wr_done   = done & pwrite & pstrb[0];
   assign sys_rst   = q_reg.sync2.system_reset;
   assign hit_cause = reg_hit(paddr, RCF_IDX_CAUSE);
   assign hit_mask  = reg_hit(paddr, RCF_IDX_MASK);
   assign set_bits  = cause_bits(q_reg.sync2);
   assign cause_clr = (wr_done & hit_cause) ? (pwdata[7:0] & RCF_IMPL_MASK) : 8'h00;
   assign mask_wr   = pwdata[7:0] & RCF_IMPL_MASK;

   always_comb begin
      q_next = q_reg;
      // only sync2 is read by logic; sync1 may be metastable
      q_next.sync1 = src;
      q_next.sync2 = q_reg.sync1;

      // set wins over a clear in the same cycle
      // flags ignore system reset entirely
      q_next.cause = ((q_reg.cause & ~cause_clr) | set_bits) & RCF_IMPL_MASK;

      // one wait state: access cycle one raises pready, the next completes
      q_next.pready  = access & ~q_reg.pready & ~sys_rst;
      q_next.pslverr = 1'b0;
      q_next.prdata  = 8'h00;
      if (access & ~q_reg.pready) begin
         // a read only samples the flags, nothing is cleared
         if (hit_cause) begin
            q_next.prdata = q_reg.cause & RCF_IMPL_MASK;
         end else if (hit_mask) begin
            q_next.prdata = q_reg.mask;
         end else begin
            q_next.pslverr = 1'b1;
         end
      end

      if (wr_done & hit_mask) begin
         q_next.mask = mask_wr;
      end
      // system reset returns control state but keeps the flags
      if (sys_rst) begin
         q_next.mask    = RCF_MASK_RST;
         q_next.pslverr = 1'b0;
         q_next.prdata  = 8'h00;
      end

      q_next.irq = |(q_next.cause & q_next.mask);
   end

   // power-on reset loads power-on and low-voltage set, others clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_reg <= RCF_STATE_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   assign prdata  = {24'h00_0000, q_reg.prdata};
   assign pready  = q_reg.pready;
   assign pslverr = q_reg.pslverr;
   assign irq     = q_reg.irq;

   // assertions; the first clock after release is told by presetn one edge back,
   // so no extra state is kept beside the register struct
   property p_por_flags;
      !$past(presetn) |-> (q_reg.cause == RCF_CAUSE_POR);
   endproperty
   a_por_flags: assert property (p_por_flags)
      else $error("flags after power-on reset are not power-on and low-voltage only");

   property p_por_both_set;
      !$past(presetn) |-> q_reg.cause[RCF_BIT_POR] && q_reg.cause[RCF_BIT_LV];
   endproperty
   a_por_both_set: assert property (p_por_both_set)
      else $error("power-on and low-voltage flags not both set after power-up");

   property p_por_clears_monitors;
      !$past(presetn) |-> !q_reg.cause[RCF_BIT_WDOG] && !q_reg.cause[RCF_BIT_OSC]
                         && !q_reg.cause[RCF_BIT_PLL];
   endproperty
   a_por_clears_monitors: assert property (p_por_clears_monitors)
      else $error("monitor flags not clear after power-on reset");

   property p_sysrst_keeps;
      (sys_rst && set_bits == 8'h00) |=> (q_reg.cause == $past(q_reg.cause));
   endproperty
   a_sysrst_keeps: assert property (p_sysrst_keeps)
      else $error("system reset changed a reset-cause flag");

   property p_lv_sets;
      (q_reg.sync2.lvr_core || q_reg.sync2.lvr_nvm_supply || q_reg.sync2.lvr_pad_supply)
         |=> q_reg.cause[RCF_BIT_LV];
   endproperty
   a_lv_sets: assert property (p_lv_sets)
      else $error("low-voltage flag not set one cycle after low-voltage reset");

   property p_wdog_sets;
      $rose(q_reg.sync2.watchdog_timer) |=> q_reg.cause[RCF_BIT_WDOG] [*2];
   endproperty
   a_wdog_sets: assert property (p_wdog_sets)
      else $error("watchdog reset flag not set after watchdog reset");

   property p_osc_sets;
      q_reg.sync2.osc_monitor |=> q_reg.cause[RCF_BIT_OSC];
   endproperty
   a_osc_sets: assert property (p_osc_sets)
      else $error("oscillator-monitor flag not set after clock loss");

   property p_pll_sets;
      q_reg.sync2.pll_monitor |=> q_reg.cause[RCF_BIT_PLL];
   endproperty
   a_pll_sets: assert property (p_pll_sets)
      else $error("pll-monitor flag not set after clock loss");

   property p_w1c_clears;
      (wr_done && hit_cause && pwdata[RCF_BIT_POR] && !set_bits[RCF_BIT_POR])
         |=> !q_reg.cause[RCF_BIT_POR];
   endproperty
   a_w1c_clears: assert property (p_w1c_clears)
      else $error("writing one did not clear the power-on flag");

   property p_w0_keeps;
      (q_reg.cause[RCF_BIT_WDOG] && !(wr_done && hit_cause && pwdata[RCF_BIT_WDOG]))
         |=> q_reg.cause[RCF_BIT_WDOG];
   endproperty
   a_w0_keeps: assert property (p_w0_keeps)
      else $error("watchdog flag cleared without a one written to it");

   property p_reserved_zero;
      (q_reg.cause[7] == 1'b0) && (q_reg.cause[4] == 1'b0) && (q_reg.cause[2] == 1'b0)
         && (prdata[31:7] == 25'h000_0000) && !prdata[4] && !prdata[2];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("unimplemented bit of the reset-cause register is not zero");

   property p_read_no_effect;
      (done && !pwrite && set_bits == 8'h00) |=> $stable(q_reg.cause);
   endproperty
   a_read_no_effect: assert property (p_read_no_effect)
      else $error("reading the reset-cause register changed a flag");

   property p_read_data;
      (access && !pready && hit_cause && !pwrite && !sys_rst)
         |=> pready && (prdata[7:0] == $past(q_reg.cause)) && !pslverr;
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read of reset-cause register returned wrong data or timing");

   property p_irq_level;
      irq == |(q_reg.cause & q_reg.mask);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output does not match masked flags");

   property p_unmapped_err;
      (access && !pready && !hit_cause && !hit_mask && !sys_rst) |=> pready && pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped access did not answer with an error");

   // bus answer: one wait state, a single-cycle pready, data and error only with it
   property p_pready_pulse;
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse)
      else $error("pready stood for more than one cycle");

   property p_setup_no_ready;
      (psel && !penable) |=> !pready;
   endproperty
   a_setup_no_ready: assert property (p_setup_no_ready)
      else $error("pready raised straight after a setup cycle");

   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("pslverr raised without pready");

   // idle read data stays zero so a stale word never leaks onto the bus
   property p_prdata_idle;
      !pready |-> (prdata == 32'h0000_0000);
   endproperty
   a_prdata_idle: assert property (p_prdata_idle)
      else $error("read data not zero outside the completing cycle");

   property p_read_mask_data;
      (access && !pready && hit_mask && !pwrite && !sys_rst)
         |=> pready && (prdata[7:0] == $past(q_reg.mask)) && !pslverr;
   endproperty
   a_read_mask_data: assert property (p_read_mask_data)
      else $error("read of the mask register returned wrong data or timing");

   property p_mask_write;
      (wr_done && hit_mask && !sys_rst) |=> (q_reg.mask == $past(mask_wr));
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("write to the mask register did not land");

   property p_strobe_ignored;
      (done && pwrite && !pstrb[0] && set_bits == 8'h00) |=> $stable(q_reg.cause);
   endproperty
   a_strobe_ignored: assert property (p_strobe_ignored)
      else $error("write without the low byte strobe changed a flag");

   property p_unmapped_write;
      (done && pwrite && !hit_cause && !hit_mask && !sys_rst && set_bits == 8'h00)
         |=> $stable(q_reg.cause) && $stable(q_reg.mask);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("write to an unmapped address changed a register");

   // system reset stalls the bus and drops the mask, never the flags
   property p_sysrst_stalls;
      sys_rst |=> !pready;
   endproperty
   a_sysrst_stalls: assert property (p_sysrst_stalls)
      else $error("bus answered during system reset");

   property p_sysrst_mask;
      sys_rst |=> (q_reg.mask == RCF_MASK_RST);
   endproperty
   a_sysrst_mask: assert property (p_sysrst_mask)
      else $error("system reset did not clear the mask register");

   property p_irq_needs_mask;
      (q_reg.mask == RCF_MASK_RST && !(wr_done && hit_mask)) |=> !irq;
   endproperty
   a_irq_needs_mask: assert property (p_irq_needs_mask)
      else $error("interrupt raised with every flag masked");

   // only power-on reset may raise the power-on flag
   property p_por_never_sets;
      !q_reg.cause[RCF_BIT_POR] |=> !q_reg.cause[RCF_BIT_POR];
   endproperty
   a_por_never_sets: assert property (p_por_never_sets)
      else $error("power-on flag set without a power-on reset");

   property p_wdog_source_sets;
      q_reg.sync2.watchdog_timer |=> q_reg.cause[RCF_BIT_WDOG];
   endproperty
   a_wdog_source_sets: assert property (p_wdog_source_sets)
      else $error("watchdog flag not set while the watchdog reset is active");

   property p_wdog_only_by_event;
      (!q_reg.cause[RCF_BIT_WDOG] && !q_reg.sync2.watchdog_timer)
         |=> !q_reg.cause[RCF_BIT_WDOG];
   endproperty
   a_wdog_only_by_event: assert property (p_wdog_only_by_event)
      else $error("watchdog flag set without a watchdog reset");

   property p_w1c_wdog;
      (wr_done && hit_cause && pwdata[RCF_BIT_WDOG] && !set_bits[RCF_BIT_WDOG])
         |=> !q_reg.cause[RCF_BIT_WDOG];
   endproperty
   a_w1c_wdog: assert property (p_w1c_wdog)
      else $error("writing one did not clear the watchdog flag");

   property p_w0_keeps_lv;
      (q_reg.cause[RCF_BIT_LV] && !(wr_done && hit_cause && pwdata[RCF_BIT_LV]))
         |=> q_reg.cause[RCF_BIT_LV];
   endproperty
   a_w0_keeps_lv: assert property (p_w0_keeps_lv)
      else $error("low-voltage flag cleared without a one written to it");

   // a clock-loss event in the cycle of a clearing write must leave the flag set
   property p_event_beats_clear;
      (wr_done && hit_cause && pwdata[RCF_BIT_OSC] && set_bits[RCF_BIT_OSC])
         |=> q_reg.cause[RCF_BIT_OSC];
   endproperty
   a_event_beats_clear: assert property (p_event_beats_clear)
      else $error("clearing write won over an oscillator-monitor event");

endmodule
